//--- shared/eer_map.svh
// constants for the display identification emulation router
// assumes a 125 MHz system clock and 7-bit serial bus addressing
`ifndef EER_MAP_SVH
`define EER_MAP_SVH

`define EER_CLK_HZ 125000000
`define EER_ATTACH_DROP_S 2
`define EER_ATTACH_DROP_CYCLES (`EER_ATTACH_DROP_S * `EER_CLK_HZ)
`define EER_DDC_DEV_ADDR 7'h50
`define EER_BLOCK_BYTES 9'h080
`define EER_EXT_COUNT_OFS 8'h7E
`define EER_BLANK_BYTE 8'hFF
`define EER_IN_COUNT 2
`define EER_OUT_COUNT 2
`define EER_STORE_SLOTS 8

`endif

//--- shared/eer_pkg.sv
// types shared by the emulation router and its serial slave
// assumes nothing beyond a SystemVerilog compiler
package eer_pkg;

    typedef enum logic [2:0] {
        EER_DDC_IDLE,
        EER_DDC_ADDR,
        EER_DDC_ADDR_ACK,
        EER_DDC_OFS,
        EER_DDC_OFS_ACK,
        EER_DDC_RDATA,
        EER_DDC_RACK
    } eer_ddc_state_e;

    typedef enum logic {
        EER_EMU_STATIC,
        EER_EMU_DYNAMIC
    } eer_emu_mode_e;

endpackage

//--- src/eer_ddc_slave.sv
// read-only display data channel slave serving one emulated structure
// assumes pins are asynchronous and the owner supplies rd_data_i for rd_addr_o within a cycle
`include "eer_map.svh"

module eer_ddc_slave (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // structure read port
    output logic [7:0] rd_addr_o,
    input wire logic [7:0] rd_data_i
);
    import eer_pkg::*;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl;
        logic sda;
        eer_ddc_state_e st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] ofs;
        logic ack;
        logic oe_n;
    } eer_ddc_s;

    eer_ddc_s q;
    eer_ddc_s next_q;
    logic nscl;
    logic nsda;
    logic rise;
    logic fall;
    logic start;
    logic stop;

    always_comb
    begin
        next_q = q;
        next_q.scl_s = {q.scl_s[1:0], scl_i};
        next_q.sda_s = {q.sda_s[1:0], sda_i};
        // a level counts only once second and third stage agree
        nscl = (q.scl_s[1] == q.scl_s[2]) ? q.scl_s[1] : q.scl;
        nsda = (q.sda_s[1] == q.sda_s[2]) ? q.sda_s[1] : q.sda;
        next_q.scl = nscl;
        next_q.sda = nsda;
        rise = nscl & ~q.scl;
        fall = ~nscl & q.scl;
        start = q.scl & nscl & q.sda & ~nsda;
        stop = q.scl & nscl & ~q.sda & nsda;
        if (start)
        begin
            next_q.st = EER_DDC_ADDR;
            next_q.cnt = 4'h0;
            next_q.oe_n = 1'b1;
        end
        else if (stop)
        begin
            next_q.st = EER_DDC_IDLE;
            next_q.oe_n = 1'b1;
        end
        else if (rise)
        begin
            case (q.st)
                EER_DDC_ADDR, EER_DDC_OFS:
                begin
                    next_q.sh = {q.sh[6:0], nsda};
                    next_q.cnt = q.cnt + 4'h1;
                end
                EER_DDC_RACK: next_q.ack = ~nsda;
                default: next_q.ack = q.ack;
            endcase
        end
        else if (fall)
        begin
            case (q.st)
                EER_DDC_ADDR:
                begin
                    if (q.cnt == 4'h8)
                    begin
                        // only the conventional address is answered
                        if (q.sh[7:1] == `EER_DDC_DEV_ADDR)
                        begin
                            next_q.st = EER_DDC_ADDR_ACK;
                            next_q.oe_n = 1'b0;
                        end
                        else
                            next_q.st = EER_DDC_IDLE;
                    end
                end
                EER_DDC_ADDR_ACK:
                begin
                    next_q.cnt = 4'h0;
                    if (q.sh[0])
                    begin
                        next_q.st = EER_DDC_RDATA;
                        next_q.sh = {rd_data_i[6:0], 1'b0};
                        next_q.oe_n = rd_data_i[7];
                        next_q.cnt = 4'h1;
                    end
                    else
                    begin
                        next_q.st = EER_DDC_OFS;
                        next_q.oe_n = 1'b1;
                    end
                end
                EER_DDC_OFS:
                begin
                    if (q.cnt == 4'h8)
                    begin
                        next_q.ofs = q.sh;
                        next_q.st = EER_DDC_OFS_ACK;
                        next_q.oe_n = 1'b0;
                    end
                end
                EER_DDC_OFS_ACK:
                begin
                    // further written bytes reload the offset; storage stays read-only
                    next_q.st = EER_DDC_OFS;
                    next_q.cnt = 4'h0;
                    next_q.oe_n = 1'b1;
                end
                EER_DDC_RDATA:
                begin
                    if (q.cnt == 4'h8)
                    begin
                        next_q.st = EER_DDC_RACK;
                        next_q.oe_n = 1'b1;
                        next_q.ofs = q.ofs + 8'h01;
                    end
                    else
                    begin
                        next_q.oe_n = q.sh[7];
                        next_q.sh = {q.sh[6:0], 1'b0};
                        next_q.cnt = q.cnt + 4'h1;
                    end
                end
                EER_DDC_RACK:
                begin
                    if (q.ack)
                    begin
                        next_q.st = EER_DDC_RDATA;
                        next_q.sh = {rd_data_i[6:0], 1'b0};
                        next_q.oe_n = rd_data_i[7];
                        next_q.cnt = 4'h1;
                    end
                    else
                        next_q.st = EER_DDC_IDLE;
                end
                default: next_q.st = EER_DDC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q <= '{scl_s: 3'h7, sda_s: 3'h7, scl: 1'b1, sda: 1'b1, st: EER_DDC_IDLE,
                   cnt: 4'h0, sh: 8'h00, ofs: 8'h00, ack: 1'b0, oe_n: 1'b1};
        end
        else
            q <= next_q;
    end

    // open-drain: the pin only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_n_o = q.oe_n;
    assign rd_addr_o = q.ofs;

endmodule

//--- src/eer_top.sv
// display identification emulation router: storage, per-input selection, attach-line pulsing
// assumes capture traffic from the output side arrives on the clock as byte writes plus a done strobe
//
// Overview of operation
// RL1: Each input has its own slave, selection and attach line, so changing one leaves the others alone.
// RL2: Structures read from each output's display are kept in storage that survives unplugging.
// RL3: Any stored slot, preset, user or captured, may be chosen for any input.
// RL4: An input emulates either a fixed stored slot or the slot tracking a chosen output.
// RL5: In tracking mode a fresh valid capture on the tracked output updates that input automatically.
// RL6: Any change of an input's emulated structure drops its attach line for 2 seconds; the code drops it only on a slot change or a valid tracked capture.
// RL7: A change is accepted while a powered source stays connected, with no cable unplug needed.
// RL8: The structure is a 128-byte base block with at most one 128-byte extension block.
// RL9: The source reads the structure over the display data channel and withholds video if it fails.
// RL10: Each input serves its structure as a read-only slave at the usual address with auto-increment.
// RL11: The attach line stays low for the whole interval and returns high with the new structure in place.
`include "eer_map.svh"

module eer_top #(
    parameter int unsigned N_IN = `EER_IN_COUNT,
    parameter int unsigned N_OUT = `EER_OUT_COUNT,
    parameter int unsigned N_SLOT = `EER_STORE_SLOTS,
    parameter int unsigned ATTACH_DROP_CYCLES = `EER_ATTACH_DROP_CYCLES,
    parameter int unsigned SW = $clog2(N_SLOT + N_OUT),
    parameter int unsigned OW = (N_OUT > 1) ? $clog2(N_OUT) : 1,
    parameter int unsigned IW = (N_IN > 1) ? $clog2(N_IN) : 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // user programming of stored slots
    input wire logic prog_we_i,
    input wire logic [SW-1:0] prog_slot_i,
    input wire logic [7:0] prog_addr_i,
    input wire logic [7:0] prog_data_i,
    // capture from displays on the outputs
    input wire logic cap_we_i,
    input wire logic [OW-1:0] cap_out_i,
    input wire logic [7:0] cap_addr_i,
    input wire logic [7:0] cap_data_i,
    input wire logic cap_done_i,
    input wire logic cap_valid_i,
    // emulation selection
    input wire logic sel_load_i,
    input wire logic [IW-1:0] sel_in_i,
    input wire eer_pkg::eer_emu_mode_e sel_mode_i,
    input wire logic [SW-1:0] sel_slot_i,
    input wire logic [OW-1:0] sel_out_i,
    // per-input source side pins
    input wire logic [N_IN-1:0] ddc_scl_i,
    input wire logic [N_IN-1:0] ddc_sda_i,
    output logic [N_IN-1:0] ddc_sda_o,
    output logic [N_IN-1:0] ddc_sda_oe_n_o,
    output logic [N_IN-1:0] sink_attach_line_o
);
    import eer_pkg::*;

    localparam int unsigned CW = $clog2(ATTACH_DROP_CYCLES + 1);
    localparam logic [CW-1:0] DROP_LOAD = CW'(ATTACH_DROP_CYCLES);
    localparam int unsigned DEPTH = (1 << SW) * 256;

    typedef struct packed {
        logic [N_IN-1:0][SW-1:0] slot;
        logic [N_IN-1:0] dyn;
        logic [N_IN-1:0][OW-1:0] track;
        logic [N_IN-1:0][CW-1:0] cnt;
        logic [N_IN-1:0] attach;
    } eer_emu_s;

    eer_emu_s q;
    eer_emu_s next_q;
    logic [7:0] store [0:DEPTH-1];
    logic [N_IN-1:0][7:0] rd_addr;
    logic [N_IN-1:0][7:0] rd_data;
    logic [SW-1:0] new_slot;

    // captured slots sit above the preset and user slots
    function automatic logic [SW-1:0] cap_slot(input logic [OW-1:0] out);
        cap_slot = SW'(N_SLOT) + SW'(out);
    endfunction

    function automatic logic [SW+7:0] mem_idx(input logic [SW-1:0] slot, input logic [7:0] addr);
        mem_idx = {slot, addr};
    endfunction

    // RL2: captured copy kept
    // no reset on storage: it stands for the non-volatile array
    always_ff @(posedge clk_i)
    begin
        if (cap_we_i)
            store[mem_idx(cap_slot(cap_out_i), cap_addr_i)] <= cap_data_i;
        else if (prog_we_i)
            store[mem_idx(prog_slot_i, prog_addr_i)] <= prog_data_i;
    end

    genvar g;
    generate
        for (g = 0; g < N_IN; g++)
        begin : gen_in
            // RL8: extension block optional
            // offsets past the base block read blank unless the base announces an extension
            always_comb
            begin
                if (rd_addr[g] >= `EER_BLOCK_BYTES
                    && store[mem_idx(q.slot[g], `EER_EXT_COUNT_OFS)] == 8'h00)
                    rd_data[g] = `EER_BLANK_BYTE;
                else
                    rd_data[g] = store[mem_idx(q.slot[g], rd_addr[g])];
            end

            // RL10: read-only slave
            // RL1: own circuit per input
            eer_ddc_slave u_ddc (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .scl_i(ddc_scl_i[g]),
                .sda_i(ddc_sda_i[g]),
                .sda_o(ddc_sda_o[g]),
                .sda_oe_n_o(ddc_sda_oe_n_o[g]),
                .rd_addr_o(rd_addr[g]),
                .rd_data_i(rd_data[g])
            );
        end
    endgenerate

    always_comb
    begin
        next_q = q;
        new_slot = '0;
        for (int i = 0; i < N_IN; i++)
        begin
            // RL11: full low interval
            if (q.cnt[i] != '0)
            begin
                next_q.cnt[i] = q.cnt[i] - CW'(1);
                if (q.cnt[i] == CW'(1))
                    next_q.attach[i] = 1'b1;
            end
            // RL4: static or tracking source
            // RL3: any slot on any input
            // RL7: no unplug needed
            if (sel_load_i && sel_in_i == IW'(i))
            begin
                new_slot = (sel_mode_i == EER_EMU_DYNAMIC) ? cap_slot(sel_out_i) : sel_slot_i;
                next_q.dyn[i] = (sel_mode_i == EER_EMU_DYNAMIC);
                next_q.track[i] = sel_out_i;
                next_q.slot[i] = new_slot;
                // RL6: drop on change
                // slot switches as the drop starts, so it is in place before release
                if (new_slot != q.slot[i])
                begin
                    next_q.attach[i] = 1'b0;
                    next_q.cnt[i] = DROP_LOAD;
                end
            end
            // RL5: tracked display replaced
            // the captured slot is rewritten in place; the drop tells the source to reread it
            else if (cap_done_i && cap_valid_i && q.dyn[i] && q.track[i] == cap_out_i)
            begin
                // RL6: drop on change
                next_q.attach[i] = 1'b0;
                next_q.cnt[i] = DROP_LOAD;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q.slot <= '0;
            q.dyn <= '0;
            q.track <= '0;
            q.cnt <= '0;
            q.attach <= '1;
        end
        else
            q <= next_q;
    end

    assign sink_attach_line_o = q.attach;

endmodule

//--- tb/eer_top_assertions.sv
// checker for the emulation router: attach pulses and slave pin behaviour
// assumes the default two-input build; bound to eer_top at the foot
module eer_top_checker #(
    parameter int unsigned N_IN = 2,
    parameter int unsigned N_OUT = 2,
    parameter int unsigned N_SLOT = 8,
    parameter int unsigned ATTACH_DROP_CYCLES = 20,
    parameter int unsigned SW = 4,
    parameter int unsigned OW = 1,
    parameter int unsigned IW = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // watched inputs
    input wire logic cap_done_i,
    input wire logic cap_valid_i,
    input wire logic [OW-1:0] cap_out_i,
    input wire logic sel_load_i,
    input wire logic [IW-1:0] sel_in_i,
    input wire eer_pkg::eer_emu_mode_e sel_mode_i,
    input wire logic [SW-1:0] sel_slot_i,
    input wire logic [OW-1:0] sel_out_i,
    input wire logic [N_IN-1:0] ddc_scl_i,
    // watched outputs
    input wire logic [N_IN-1:0] ddc_sda_o,
    input wire logic [N_IN-1:0] ddc_sda_oe_n_o,
    input wire logic [N_IN-1:0] sink_attach_line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import eer_pkg::*;
    logic [SW-1:0] cur [N_IN];
    logic [N_IN-1:0] dyn;
    logic [OW-1:0] trk [N_IN];
    int unsigned cnt [N_IN];
    logic [N_IN-1:0] cause;
    logic [SW-1:0] want;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    assign want = (sel_mode_i == EER_EMU_DYNAMIC) ? SW'(N_SLOT + sel_out_i) : sel_slot_i;
    // a load wins over a capture on its own input
    always_comb
    begin
        for (int i = 0; i < N_IN; i++)
        begin
            cause[i] = (sel_load_i && sel_in_i == IW'(i)) ? want != cur[i]
                : cap_done_i && cap_valid_i && dyn[i] && cap_out_i == trk[i];
        end
    end
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        for (int i = 0; i < N_IN; i++)
        begin
            if (rst_i)
            begin
                cur[i] <= '0;
                dyn[i] <= 1'b0;
                trk[i] <= '0;
                cnt[i] <= 0;
            end
            else
            begin
                if (sel_load_i && sel_in_i == IW'(i))
                begin
                    cur[i] <= want;
                    dyn[i] <= sel_mode_i == EER_EMU_DYNAMIC;
                    trk[i] <= sel_out_i;
                end
                cnt[i] <= cause[i] ? ATTACH_DROP_CYCLES : (cnt[i] != 0 ? cnt[i] - 1 : 0);
            end
        end
    end
    sequence s_load_quiet;
        sel_load_i && !cap_done_i;
    endsequence
    a_attach_in0_len: assert property (sink_attach_line_o[0] == (cnt[0] == 0))
        else $error("input 0 attach line off its interval");
    a_attach_in1_len: assert property (sink_attach_line_o[1] == (cnt[1] == 0))
        else $error("input 1 attach line off its interval");
    a_drop_prompt: assert property (cause[0] |=> !sink_attach_line_o[0] [*4])
        else $error("input 0 attach line did not drop");
    a_dyn_capture_drop: assert property (cap_done_i && cause[1] |=> !sink_attach_line_o[1])
        else $error("tracked capture did not drop input 1");
    a_other_input_kept: assert property (s_load_quiet ##0 sink_attach_line_o[~sel_in_i]
        |=> sink_attach_line_o[~$past(sel_in_i)]) else $error("other input attach line disturbed");
    a_same_no_drop: assert property (s_load_quiet ##0 (!cause[sel_in_i] && sink_attach_line_o[sel_in_i])
        |=> sink_attach_line_o[$past(sel_in_i)]) else $error("unchanged selection dropped attach");
    a_open_drain: assert property (ddc_sda_o == '0)
        else $error("data pin driven high");
    a_oe_scl_low: assert property ($changed(ddc_sda_oe_n_o[0]) |-> !ddc_scl_i[0] && !$past(ddc_scl_i[0], 2))
        else $error("data enable moved while bus clock high");
    a_reset_idle: assert property ($fell(rst_i) |-> &ddc_sda_oe_n_o && &sink_attach_line_o)
        else $error("pins not idle after reset");
endmodule

bind eer_top eer_top_checker #(.N_IN(N_IN), .N_OUT(N_OUT), .N_SLOT(N_SLOT),
    .ATTACH_DROP_CYCLES(ATTACH_DROP_CYCLES), .SW(SW), .OW(OW), .IW(IW)) i_eer_top_checker (
    .clk_i(clk_i), .rst_i(rst_i), .cap_done_i(cap_done_i), .cap_valid_i(cap_valid_i),
    .cap_out_i(cap_out_i), .sel_load_i(sel_load_i), .sel_in_i(sel_in_i), .sel_mode_i(sel_mode_i),
    .sel_slot_i(sel_slot_i), .sel_out_i(sel_out_i), .ddc_scl_i(ddc_scl_i), .ddc_sda_o(ddc_sda_o),
    .ddc_sda_oe_n_o(ddc_sda_oe_n_o), .sink_attach_line_o(sink_attach_line_o));

//--- tb/eer_src_model.sv
// video source model reading one input's structure over the data channel
// assumes the bench resolves the data wire with a pull-up
module eer_src_model (
    // clock
    input wire logic clk_i,
    // bus pins
    output logic scl_o,
    output logic sda_o,
    input wire logic sda_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // well above the slave's synchroniser delay
    localparam int HALF = 20;
    logic [7:0] junk;
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic hold();
        repeat (HALF) @(negedge clk_i);
    endtask
    // data moves only while clock low
    task automatic bit_io(input logic b, output logic r);
        sda_o = b;
        hold();
        scl_o = 1'b1;
        hold();
        r = sda_i;
        scl_o = 1'b0;
        hold();
    endtask
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(d[i], q[i]);
        end
    endtask
    task automatic start();
        sda_o = 1'b1;
        hold();
        scl_o = 1'b1;
        hold();
        sda_o = 1'b0;
        hold();
        scl_o = 1'b0;
    endtask
    // offset write, repeated start, sequential read, nack on last
    task automatic fetch(input logic [6:0] dev, input logic [7:0] ofs, input int n,
                         output logic nak, output logic [7:0] q [3]);
        logic a;
        start();
        byte_io({dev, 1'b0}, junk);
        bit_io(1'b1, nak);
        if (!nak)
        begin
            byte_io(ofs, junk);
            bit_io(1'b1, a);
            start();
            byte_io({dev, 1'b1}, junk);
            bit_io(1'b1, a);
            for (int i = 0; i < n; i++)
            begin
                byte_io(8'hFF, q[i]);
                bit_io(i == n - 1, a);
            end
        end
        sda_o = 1'b0;
        hold();
        scl_o = 1'b1;
        hold();
        sda_o = 1'b1;
        hold();
    endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench for the emulation router, one reader model per input
// assumes the checker is bound from its own file
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import eer_pkg::*;
    // short drop keeps the run brief
    localparam int unsigned D = 20;
    logic clk = 1'b0, rst = 1'b1, pwe = 1'b0, cwe = 1'b0, cout = 1'b0, cdone = 1'b0, cval = 1'b0;
    logic sload = 1'b0, sin = 1'b0, sout = 1'b0;
    logic [3:0] pslot = 4'h0, sslot = 4'h0;
    logic [7:0] paddr = 8'h00, pdata = 8'h00, caddr = 8'h00, cdata = 8'h00;
    eer_emu_mode_e smode = EER_EMU_STATIC;
    wire [1:0] scl, msda, sda, sda_o, oe_n, attach;
    int miscompares = 0;
    int tests_run = 0;
    eer_top #(.ATTACH_DROP_CYCLES(D)) i_eer_top (.clk_i(clk), .rst_i(rst), .prog_we_i(pwe),
        .prog_slot_i(pslot), .prog_addr_i(paddr), .prog_data_i(pdata), .cap_we_i(cwe), .cap_out_i(cout),
        .cap_addr_i(caddr), .cap_data_i(cdata), .cap_done_i(cdone), .cap_valid_i(cval), .sel_load_i(sload),
        .sel_in_i(sin), .sel_mode_i(smode), .sel_slot_i(sslot), .sel_out_i(sout), .ddc_scl_i(scl),
        .ddc_sda_i(sda), .ddc_sda_o(sda_o), .ddc_sda_oe_n_o(oe_n), .sink_attach_line_o(attach));
    eer_src_model i_src0 (.clk_i(clk), .scl_o(scl[0]), .sda_o(msda[0]), .sda_i(sda[0]));
    eer_src_model i_src1 (.clk_i(clk), .scl_o(scl[1]), .sda_o(msda[1]), .sda_i(sda[1]));
    // pulled up: low when either side pulls
    assign sda = msda & (oe_n | sda_o);
    initial
    begin
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] pat(input logic [3:0] s, input logic [7:0] a);
        return (s == 4'h0 && a == 8'h7E) ? 8'h00 : a ^ {s, 4'hA};
    endfunction
    task automatic prog(input logic [3:0] s);
        pslot = s;
        pwe = 1'b1;
        for (int a = 0; a < 256; a++)
        begin
            paddr = 8'(a);
            pdata = pat(s, 8'(a));
            @(negedge clk);
        end
        pwe = 1'b0;
    endtask
    task automatic capt(input logic o, input logic [3:0] salt, input logic v);
        cout = o;
        cwe = 1'b1;
        for (int a = 0; a < 256; a++)
        begin
            caddr = 8'(a);
            cdata = pat(salt, 8'(a));
            @(negedge clk);
        end
        cwe = 1'b0;
        cdone = 1'b1;
        cval = v;
        @(negedge clk);
        cdone = 1'b0;
    endtask
    task automatic sel(input logic i, input eer_emu_mode_e m, input logic [3:0] s, input logic o);
        sin = i;
        smode = m;
        sslot = s;
        sout = o;
        sload = 1'b1;
        @(negedge clk);
        sload = 1'b0;
    endtask
    task automatic low_len(input int i, input int exp);
        int n = 0;
        while (attach[i] === 1'b0 && n < 1000)
        begin
            n++;
            @(negedge clk);
        end
        chk(n, exp);
    endtask
    task automatic rd(input int i, input logic [7:0] ofs, input logic [7:0] e0, e1, e2);
        logic nak;
        logic [7:0] q [3];
        if (i == 0)
            i_src0.fetch(7'h50, ofs, 3, nak, q);
        else
            i_src1.fetch(7'h50, ofs, 3, nak, q);
        chk(nak, 1'b0);
        chk({q[0], q[1], q[2]}, {e0, e1, e2});
    endtask
    task automatic t_serve();
        logic nak;
        logic [7:0] q [3];
        chk({attach, oe_n, sda_o}, 6'h3C);
        prog(4'h0);
        prog(4'h3);
        rd(0, 8'h7E, 8'h00, pat(4'h0, 8'h7F), 8'hFF);
        rd(1, 8'h00, pat(4'h0, 8'h00), pat(4'h0, 8'h01), pat(4'h0, 8'h02));
        i_src0.fetch(7'h51, 8'h00, 1, nak, q);
        chk(nak, 1'b1);
    endtask
    task automatic t_static();
        sel(1'b0, EER_EMU_STATIC, 4'h3, 1'b0);
        chk(attach[1], 1'b1);
        low_len(0, D);
        rd(0, 8'hFE, pat(4'h3, 8'hFE), pat(4'h3, 8'hFF), pat(4'h3, 8'h00));
        sel(1'b0, EER_EMU_STATIC, 4'h3, 1'b0);
        low_len(0, 0);
        sel(1'b0, EER_EMU_STATIC, 4'h0, 1'b0);
        repeat (9) @(negedge clk);
        sel(1'b0, EER_EMU_STATIC, 4'h3, 1'b0);
        low_len(0, D);
    endtask
    task automatic t_dynamic();
        capt(1'b1, 4'h5, 1'b1);
        low_len(1, 0);
        sel(1'b1, EER_EMU_DYNAMIC, 4'h0, 1'b1);
        low_len(1, D);
        rd(1, 8'h00, pat(4'h5, 8'h00), pat(4'h5, 8'h01), pat(4'h5, 8'h02));
        capt(1'b1, 4'h6, 1'b1);
        chk(attach[0], 1'b1);
        low_len(1, D);
        rd(1, 8'h00, pat(4'h6, 8'h00), pat(4'h6, 8'h01), pat(4'h6, 8'h02));
        capt(1'b0, 4'h7, 1'b1);
        low_len(1, 0);
        capt(1'b1, 4'h8, 1'b0);
        low_len(1, 0);
        sel(1'b0, EER_EMU_STATIC, 4'h8, 1'b0);
        low_len(0, D);
        rd(0, 8'h00, pat(4'h7, 8'h00), pat(4'h7, 8'h01), pat(4'h7, 8'h02));
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #800000;
        miscompares++;
        report_and_stop();
    end
    initial
    begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_serve();
        t_static();
        t_dynamic();
        report_and_stop();
    end
endmodule
